// [tprc_checker.sv]
`timescale 1ns/100ps
module tprc_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link signals
    input wire logic scanclk,
    input wire logic scanclkena,
    input wire logic scandata,
    input wire logic configupdate,
    input wire logic areset,
    input wire logic reconfig_done,
    input wire logic scandataout
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Properties over the link
    property p_rst_after_done;
        $rose(reconfig_done) |-> ##[1:3] areset;
    endproperty
    property p_rst_len;
        $rose(areset) && reconfig_done |-> areset[*8];
    endproperty
    property p_done_clears;
        areset && reconfig_done |-> ##[1:5] !reconfig_done;
    endproperty
    property p_clk_gated;
        !scanclkena && !$past(scanclkena) |-> $stable(scanclk);
    endproperty
    property p_data_on_fall;
        scanclkena && $past(scanclkena) && $changed(scandata) |-> $fell(scanclk);
    endproperty
    property p_sclk_high;
        $rose(scanclk) |-> scanclk[*4] ##1 !scanclk;
    endproperty
    property p_upd_len;
        $rose(configupdate) |-> !scanclkena && configupdate[*4] ##1 !configupdate;
    endproperty
    property p_done_after_upd;
        $rose(configupdate) |-> ##[1:12] reconfig_done;
    endproperty
    a_rst_after_done: assert property (p_rst_after_done) else $error("no reset after done");
    a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
    a_done_clears: assert property (p_done_clears) else $error("done stuck");
    a_clk_gated: assert property (p_clk_gated) else $error("scan clock moved");
    a_data_on_fall: assert property (p_data_on_fall) else $error("data off edge");
    a_sclk_high: assert property (p_sclk_high) else $error("scan clock period");
    a_upd_len: assert property (p_upd_len) else $error("update length");
    a_done_after_upd: assert property (p_done_after_upd) else $error("done late");
    // Main scenarios reached
    c_upd: cover property ($rose(configupdate));
    c_done: cover property ($rose(reconfig_done));
    c_rst: cover property ($fell(areset));
endmodule : tprc_checker

// [tprc_ctrl.sv]
`timescale 1ns/100ps
module tprc_ctrl
    import tprc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Image taken from the external ROM and start request
    input wire logic start_in,
    input wire logic [CHAIN_BITS-1:0] rom_word_in,
    // User PLL reset for the normal reset sequence
    input wire logic user_pll_reset_in,
    // Link to the device
    tprc_link_if.ctrl link,
    // Status
    output logic busy_out,
    output logic rate_refused_out,
    output logic [CHAIN_BITS-1:0] readback_out
);
    tprc_cstate_type state_q;
    logic [CHAIN_BITS-1:0] sh_q, rb_q;
    logic [4:0] bit_q;
    logic [2:0] div_q;
    logic [3:0] rcnt_q;
    logic sclk_q, ena_q, upd_q, arst_q, ref_q;
    logic [2:0] done_s_q, dout_s_q;

    // Rate must fit the channel mode before a reconfiguration starts
    // mode supports rate
    wire rate_ok = rom_word_in[RATE_LSB +: RATE_BITS] <= RATE_MAX_MODE;
    wire half_tick = (div_q == 3'(SCLK_HALF - 1));
    wire fall_tick = half_tick & sclk_q;
    wire done_lvl = done_s_q[2];
    wire done_rise = done_s_q[1] & ~done_s_q[2];

    // Done and readback samplers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_s_q <= 3'h0;
            dout_s_q <= 3'h0;
        end else begin
            done_s_q <= {done_s_q[1:0], link.reconfig_done};
            dout_s_q <= {dout_s_q[1:0], link.scandataout};
        end
    end

    // Sequencer; the scan clock is divided down and runs only while shifting
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= CS_IDLE;
            sh_q <= '0;
            rb_q <= '0;
            bit_q <= 5'h00;
            div_q <= 3'h0;
            rcnt_q <= 4'h0;
            sclk_q <= 1'b0;
            ena_q <= 1'b0;
            upd_q <= 1'b0;
            arst_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            case (state_q)
                CS_IDLE: begin
                    arst_q <= user_pll_reset_in;
                    if (start_in) begin
                        ref_q <= ~rate_ok;
                        if (rate_ok) begin
                            sh_q <= rom_word_in;
                            bit_q <= 5'h00;
                            div_q <= 3'h0;
                            ena_q <= 1'b1;
                            state_q <= CS_SHIFT;
                        end
                    end
                end
                CS_SHIFT: begin
                    div_q <= half_tick ? 3'h0 : div_q + 3'h1;
                    if (half_tick) begin
                        sclk_q <= ~sclk_q;
                    end
                    if (fall_tick) begin
                        sh_q <= {sh_q[CHAIN_BITS-2:0], 1'b0};
                        rb_q <= {rb_q[CHAIN_BITS-2:0], dout_s_q[2]};
                        bit_q <= bit_q + 5'h01;
                        if (bit_q == 5'(CHAIN_BITS - 1)) begin
                            ena_q <= 1'b0;
                            state_q <= CS_UPDATE;
                        end
                    end
                end
                CS_UPDATE: begin
                    upd_q <= 1'b1;
                    div_q <= div_q + 3'h1;
                    // Update stands SCLK_HALF cycles
                    if (div_q == 3'(SCLK_HALF)) begin
                        upd_q <= 1'b0;
                        state_q <= CS_WAIT;
                    end
                end
                CS_WAIT: begin
                    if (done_rise | done_lvl) begin
                        arst_q <= 1'b1;
                        rcnt_q <= 4'h0;
                        state_q <= CS_RESET;
                    end
                end
                CS_RESET: begin
                    rcnt_q <= rcnt_q + 4'h1;
                    if (rcnt_q == 4'(PLLRST_CYCLES - 1)) begin
                        arst_q <= 1'b0;
                        state_q <= CS_IDLE;
                    end
                end
                default: state_q <= CS_IDLE;
            endcase
        end
    end

    // Registered link pins; the MSB of the shift word is the bit on the wire
    // user reset reaches PLL reset through arst_q, and only while idle
    assign link.areset = arst_q;
    assign link.scanclk = sclk_q;
    assign link.scanclkena = ena_q;
    assign link.scandata = sh_q[CHAIN_BITS-1];
    assign link.configupdate = upd_q;
    assign busy_out = (state_q != CS_IDLE);
    assign rate_refused_out = ref_q;
    assign readback_out = rb_q;
endmodule : tprc_ctrl

// [tprc_device.sv]
`timescale 1ns/100ps
module tprc_device
    import tprc_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link to the reconfiguration controller
    tprc_link_if.dev link,
    // Receiver core clocking choice and channel clocks (as levels)
    input wire tprc_rxclk_type rxclk_sel_in,
    input wire logic [CHANNELS-1:0] tx_clkout_in,
    input wire logic [CHANNELS-1:0] rx_clkout_in,
    input wire logic [CHANNELS-1:0] chan_cfg_we_in,
    input wire logic [7:0] chan_cfg_in,
    // Status
    output logic [CHANNELS-1:0] rxfifo_rdclk_out,
    output logic [RATE_BITS-1:0] pll_rate_out,
    output logic pll_in_reset_out,
    output logic [CHANNELS*RATE_BITS-1:0] chan_rate_out,
    output logic [CHANNELS*8-1:0] chan_cfg_out
);
    // Three-stage samplers for every link input from the other domain
    logic [2:0] sclk_s_q, ena_s_q, dat_s_q, upd_s_q, rst_s_q;
    logic [CHAIN_BITS-1:0] chain_q;
    logic [RATE_BITS-1:0] rate_q;
    logic done_q, dout_q, inrst_q, upd_seen_q;
    logic [CHANNELS-1:0] rdclk_q;
    logic [CHANNELS*8-1:0] cfg_q;
    // Settled levels of the link inputs
    logic sclk_f_q, ena_f_q, dat_f_q, upd_f_q, rst_f_q;

    // A change counts only once stages two and three agree; otherwise the held level stays
    function automatic logic settle(input logic [2:0] stages, input logic held);
        logic agreed;
        agreed = (stages[1] == stages[2]);
        return agreed ? stages[2] : held;
    endfunction : settle

    // Next settled levels; costs one cycle of latency, but a one-sample glitch never counts
    wire sclk_f_d = settle(sclk_s_q, sclk_f_q);
    wire ena_f_d = settle(ena_s_q, ena_f_q);
    wire dat_f_d = settle(dat_s_q, dat_f_q);
    wire upd_f_d = settle(upd_s_q, upd_f_q);
    wire rst_f_d = settle(rst_s_q, rst_f_q);

    // Edges are taken against the held level, so each scan clock rise acts exactly once
    wire sclk_rise = sclk_f_d & ~sclk_f_q;
    wire upd_rise = upd_f_d & ~upd_f_q;
    // Levels come from the held copies; the controller keeps data steady half a scan period around a rise
    wire ena_lvl = ena_f_q;
    wire dat_lvl = dat_f_q;
    wire rst_lvl = rst_f_q;
    wire scan_tick = sclk_rise & ena_lvl;

    // Synchronisers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sclk_s_q <= 3'h0;
            ena_s_q <= 3'h0;
            dat_s_q <= 3'h0;
            upd_s_q <= 3'h0;
            rst_s_q <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], link.scanclk};
            ena_s_q <= {ena_s_q[1:0], link.scanclkena};
            dat_s_q <= {dat_s_q[1:0], link.scandata};
            upd_s_q <= {upd_s_q[1:0], link.configupdate};
            rst_s_q <= {rst_s_q[1:0], link.areset};
        end
    end

    // Held link levels; reset to the idle level of every pin so no false edge follows reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sclk_f_q <= 1'b0;
            ena_f_q <= 1'b0;
            dat_f_q <= 1'b0;
            upd_f_q <= 1'b0;
            rst_f_q <= 1'b0;
        end else begin
            sclk_f_q <= sclk_f_d;
            ena_f_q <= ena_f_d;
            dat_f_q <= dat_f_d;
            upd_f_q <= upd_f_d;
            rst_f_q <= rst_f_d;
        end
    end

    // Scan chain; it keeps the last image shifted in, which is the live PLL setting after an update
    // Readback lags one bit: the controller sees the bit left over from the last shift first, then the old image less its LSB
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chain_q <= CHAIN_BITS'(RATE_RST);
            dout_q <= 1'b0;
        end else if (scan_tick) begin
            chain_q <= {chain_q[CHAIN_BITS-2:0], dat_lvl};
            dout_q <= chain_q[CHAIN_BITS-1];
        end
    end

    // Apply update; done rises, then the PLL reset completes the change
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rate_q <= RATE_RST;
            done_q <= 1'b0;
            upd_seen_q <= 1'b0;
            inrst_q <= 1'b0;
        end else begin
            // PLL in reset follows the settled reset pin
            inrst_q <= rst_lvl;
            if (upd_rise) begin
                rate_q <= chain_q[RATE_LSB +: RATE_BITS];
                upd_seen_q <= 1'b1;
                done_q <= 1'b0;
            end else if (upd_seen_q) begin
                done_q <= 1'b1;
                upd_seen_q <= 1'b0;
            end else if (rst_lvl) begin
                done_q <= 1'b0;
            end
        end
    end

    // Channel settings: only local writes change them, never the PLL path
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_q <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (chan_cfg_we_in[i]) begin
                    cfg_q[i*8 +: 8] <= chan_cfg_in;
                end
            end
        end
    end

    // Receive FIFO read clock selection per channel
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdclk_q <= '0;
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                case (rxclk_sel_in)
                    // Shared choice: channel 0 transmit clock for every receiver
                    RXCLK_SHARED: rdclk_q[i] <= tx_clkout_in[0];
                    RXCLK_TX_OWN: rdclk_q[i] <= tx_clkout_in[i];
                    RXCLK_RX_OWN: rdclk_q[i] <= rx_clkout_in[i];
                    default: rdclk_q[i] <= tx_clkout_in[0];
                endcase
            end
        end
    end

    // Every channel reports the PLL rate; none keeps its own copy
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chan_rate_out <= {CHANNELS{RATE_RST}};
        end else begin
            chan_rate_out <= {CHANNELS{rate_q}};
        end
    end

    // Registered outputs
    // Every pin and status output is a flop, so the controller never sees a combinational glitch
    assign link.reconfig_done = done_q;
    assign link.scandataout = dout_q;
    assign rxfifo_rdclk_out = rdclk_q;
    assign pll_rate_out = rate_q;
    assign pll_in_reset_out = inrst_q;
    assign chan_cfg_out = cfg_q;
endmodule : tprc_device

// [tprc_link_if.sv]
`timescale 1ns/100ps
interface tprc_link_if;
    logic scanclk;
    logic scanclkena;
    logic scandata;
    logic configupdate;
    logic areset;
    logic reconfig_done;
    logic scandataout;
    // Controller end drives the scan pins and the PLL reset
    modport ctrl (
        output scanclk, scanclkena, scandata, configupdate, areset,
        input reconfig_done, scandataout
    );
    // Device end receives them and reports completion
    modport dev (
        input scanclk, scanclkena, scandata, configupdate, areset,
        output reconfig_done, scandataout
    );
endinterface : tprc_link_if

// [tprc_pkg.sv]
package tprc_pkg;
    // Scan chain length of the reconfigurable PLL, in bits
    localparam int CHAIN_BITS = 18;
    // Width of the divide ratio that sets the data rate
    localparam int RATE_BITS = 8;
    // Reset value of the PLL divide ratio
    localparam logic [7:0] RATE_RST = 8'h04;
    // Bit positions of the rate field inside the scan word
    localparam int RATE_LSB = 0;
    // Rate ceiling supported by the channel functional modes
    localparam logic [7:0] RATE_MAX_MODE = 8'h20;
    // Controller divides clk_in by 2*SCLK_HALF for the scan clock
    localparam int SCLK_HALF = 4;
    // PLL reset pulse length from the controller, in clk_in cycles
    localparam int PLLRST_CYCLES = 8;
    // Receiver core clocking choices
    typedef enum logic [1:0] {
        RXCLK_SHARED = 2'h0,
        RXCLK_TX_OWN = 2'h1,
        RXCLK_RX_OWN = 2'h2
    } tprc_rxclk_type;
    // Controller states
    typedef enum logic [4:0] {
        CS_IDLE = 5'h01,
        CS_SHIFT = 5'h02,
        CS_UPDATE = 5'h04,
        CS_WAIT = 5'h08,
        CS_RESET = 5'h10
    } tprc_cstate_type;
endpackage : tprc_pkg

// [transceiver_pll_reconfig_port_bench.sv]
`timescale 1ns/100ps
module transceiver_pll_reconfig_port_bench;
    import tprc_pkg::*;
    localparam int CH = 4;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    logic user_pll_reset_in = 1'b0;
    logic [CHAIN_BITS-1:0] rom_word_in = '0;
    tprc_rxclk_type rxclk_sel_in = RXCLK_SHARED;
    logic [CH-1:0] tx_clkout_in = '0, rx_clkout_in = '0, chan_cfg_we_in = '0;
    logic [7:0] chan_cfg_in = 8'h00;
    logic busy_out, rate_refused_out, pll_in_reset_out;
    logic [CHAIN_BITS-1:0] readback_out;
    logic [CH-1:0] rxfifo_rdclk_out;
    logic [7:0] pll_rate_out;
    logic [CH*8-1:0] chan_rate_out, chan_cfg_out;
    logic [7:0] rate_m = RATE_RST;
    logic [7:0] cfg_m[CH];
    logic [CH-1:0] rd_m;
    logic [CHAIN_BITS-1:0] img_m = CHAIN_BITS'(RATE_RST);
    logic [CHAIN_BITS-1:0] rb_m = '0;
    logic dout_m = 1'b0;
    int fails = 0;
    int num_checks = 0;
    tprc_link_if link ();
    // The two ends face each other
    // pins joined directly
    tprc_device #(.CHANNELS(CH)) i_tprc_device (.clk_in, .rst_in, .link(link), .rxclk_sel_in, .tx_clkout_in,
        .rx_clkout_in, .chan_cfg_we_in, .chan_cfg_in, .rxfifo_rdclk_out, .pll_rate_out, .pll_in_reset_out,
        .chan_rate_out, .chan_cfg_out);
    tprc_ctrl i_tprc_ctrl (.clk_in, .rst_in, .start_in, .rom_word_in, .user_pll_reset_in, .link(link),
        .busy_out, .rate_refused_out, .readback_out);
    tprc_checker u_chk (.clk_in, .rst_in, .scanclk(link.scanclk), .scanclkena(link.scanclkena),
        .scandata(link.scandata), .configupdate(link.configupdate), .areset(link.areset),
        .reconfig_done(link.reconfig_done), .scandataout(link.scandataout));
    // 20 MHz clock
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // Channel state must survive any PLL change
    task automatic chans();
        for (int i = 0; i < CH; i++) begin
            chk("chan rate", chan_rate_out[i*8+:8], rate_m);
            chk("chan cfg", chan_cfg_out[i*8+:8], cfg_m[i]);
        end
    endtask : chans
    // One reconfiguration; rates above the mode ceiling are refused
    task automatic reconfig(logic [7:0] rate);
        int n;
        logic ok;
        logic rst_seen;
        ok = rate <= RATE_MAX_MODE;
        rst_seen = 1'b0;
        n = 0;
        rom_word_in = {(CHAIN_BITS-8)'($urandom), rate};
        start_in = 1'b1;
        tick();
        start_in = 1'b0;
        while (busy_out === 1'b1 && n < 1000) begin
            tick();
            n++;
            rst_seen = rst_seen | (pll_in_reset_out === 1'b1);
        end
        tick(2);
        // Readback model: last bit left over, then the previous image less its LSB
        if (ok) begin
            rate_m = rate;
            rb_m = {dout_m, img_m[CHAIN_BITS-1:1]};
            dout_m = img_m[0];
            img_m = rom_word_in;
        end
        chk("no hang", n < 1000, 1);
        chk("refused", rate_refused_out, !ok);
        chk("pll rate", pll_rate_out, rate_m);
        chk("readback", readback_out, rb_m);
        chk("pll reset", rst_seen, ok);
        chans();
    endtask : reconfig
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h1198));
        tick(16);
        rst_in = 1'b0;
        tick();
        chk("rate reset", pll_rate_out, RATE_RST);
        chk("done reset", link.reconfig_done, 0);
        // Per-channel settings
        for (int i = 0; i < CH; i++) begin
            chan_cfg_we_in = CH'(1 << i);
            chan_cfg_in = 8'($urandom);
            cfg_m[i] = chan_cfg_in;
            tick();
        end
        chan_cfg_we_in = '0;
        tick(2);
        chans();
        $display("test chancfg done");
        // Receive FIFO read clock selection
        for (int k = 0; k < 12; k++) begin
            rxclk_sel_in = tprc_rxclk_type'(k % 3);
            tx_clkout_in = CH'($urandom);
            rx_clkout_in = CH'($urandom);
            tick(3);
            rd_m = (k % 3 == 0) ? {CH{tx_clkout_in[0]}} : (k % 3 == 1) ? tx_clkout_in : rx_clkout_in;
            chk("rd clock", rxfifo_rdclk_out, rd_m);
        end
        $display("test rxclk done");
        // Boundary, refused, extremes, then random back to back
        reconfig(RATE_MAX_MODE);
        reconfig(RATE_MAX_MODE + 8'h01);
        reconfig(8'hFF);
        reconfig(8'h01);
        for (int k = 0; k < 4; k++) reconfig(8'($urandom_range(0, 32)));
        $display("test reconfig done");
        // User reset passes through while idle
        user_pll_reset_in = 1'b1;
        // The PLL sees the pin through three samplers and a settled level
        tick(8);
        chk("user reset", link.areset, 1);
        chk("pll in reset", pll_in_reset_out, 1);
        user_pll_reset_in = 1'b0;
        tick(3);
        chk("user release", link.areset, 0);
        tick(5);
        chk("pll out of reset", pll_in_reset_out, 0);
        chans();
        $display("test userreset done");
        give_verdict();
    end
endmodule : transceiver_pll_reconfig_port_bench
